// ==== cpb_pkg.sv ====
`default_nettype none
package cpb_pkg;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [19:0] RESET_VECTOR = 20'hFFFF0;
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam logic [1:0] DATA_CYCLES = 2'h2;
  localparam logic [2:0] UPPER_DATA_ZERO = 3'h0;
  localparam logic RESET_INDICATOR_ON = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    stReset,
    stAlign,
    stIdle,
    stAddr,
    stData,
    stHold,
    stPdown,
    stWakeDrive,
    stWakeWait
  } cpb_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic dmaOrRefresh;
    logic [19:0] addr;
    logic [15:0] wdata;
  } cpb_bus_req_t;

  typedef struct packed {
    logic [15:0] adOut;
    logic [15:0] adOe;
    logic [3:0] upperOut;
    logic upperOe;
  } cpb_bus_pins_t;

endpackage
`default_nettype wire

// ==== cpb_pins.sv ====
`default_nettype none

// Summary of operation
// - Timing reference output runs at half the double-rate input clock.
// - Timing reference toggles on every falling input edge, giving 50% duty.
// - Reset request aborts any bus cycle in any mode and initializes the device.
// - In reset every pin takes a defined state and reset indicator is asserted.
// - On reset release, align timing output, then fetch from address 0FFFF0H.
// - Reset indicator stays asserted while reset request stays asserted.
// - Test/busy pin sampled in reset selects coprocessor mode; tie forces it.
// - Outside coprocessor mode, wait stalls until test pin is sampled low.
// - Non-maskable interrupt edge is latched and serviced as type 2.
// - Address phase shows low address on muxed bus; data phase moves data.
// - Address phase drives address bits 16 to 19 on upper pins.
// - Data phase forces upper address bits 18 to 16 to zero.
// - Data phase drives bit-19 status low for CPU, high for DMA or refresh.
// - Narrow bus keeps address bits 15 to 8 valid for the whole cycle.
// - Crystal drive output keeps driving, also in on-circuit emulation mode.
// - After power-down exit, wait for the wake delay pin before resuming.
// - Muxed bus and upper pins float while the bus is granted away.
// - Muxed bus and upper pins keep their levels during power-down.
module cpb_pins (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Clock pins
  input wire logic doubleRateClockIn,
  output logic halfRateTimingOut_q,
  output logic crystalDriveOut_q,
  output logic crystalDriveOe_q,
  input wire logic onCircuitEmulationMode,
  // Reset pins
  input wire logic resetRequestIn_b,
  output logic resetIndicatorOut_q,
  // Test/busy and wait
  input wire logic testBusyIn,
  input wire logic waitReq,
  output logic waitStall_q,
  output logic coprocMode_q,
  output logic coprocBusy_q,
  // Non-maskable interrupt
  input wire logic nmiIn,
  input wire logic nmiAck,
  output logic nmiPending_q,
  output logic [7:0] nmiType_q,
  // Power-down and wake delay pin
  input wire logic powerDownReq,
  input wire logic wakeReq,
  input wire logic powerdownWakeDelayIn,
  output logic powerdownWakeDelayOut_q,
  output logic powerdownWakeDelayOe_q,
  output logic powerDown_q,
  // Bus hold
  input wire logic holdReq,
  output logic holdAck_q,
  // Bus request side
  input wire logic narrowBus,
  input wire cpb_pkg::cpb_bus_req_t busReq,
  output logic busAck_q,
  output logic [15:0] busRdata_q,
  // Bus pins
  input wire logic [15:0] muxedAddrDataIn,
  output cpb_pkg::cpb_bus_pins_t busPins_q
);

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  logic clkInPrev_q;
  logic clkInPrev_d;
  logic halfRate_d;
  logic crystal_d;
  logic clkInFall;
  logic resetRelease;

  assign clkInFall = clkInPrev_q & ~doubleRateClockIn;

  always_comb begin
    clkInPrev_d = doubleRateClockIn;
    crystal_d = ~doubleRateClockIn;
    halfRate_d = halfRateTimingOut_q;
    if (resetRelease) begin
      halfRate_d = 1'b0;
    end else if (clkInFall) begin
      halfRate_d = ~halfRateTimingOut_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkInPrev_q <= 1'b0;
      halfRateTimingOut_q <= 1'b0;
      crystalDriveOut_q <= 1'b0;
      crystalDriveOe_q <= 1'b1;
    end else begin
      clkInPrev_q <= clkInPrev_d;
      halfRateTimingOut_q <= halfRate_d;
      crystalDriveOut_q <= crystal_d;
      // Emulation mode does not release the crystal drive
      crystalDriveOe_q <= 1'b1 | onCircuitEmulationMode;
    end
  end

  // ----------------------------------------------------------------
  // Reset indicator and mode strap
  // ----------------------------------------------------------------
  logic resetReqPrev_q;
  logic resetReqPrev_d;
  logic resetInd_d;
  logic strap_q;
  logic strap_d;
  logic coproc_d;

  assign resetRelease = resetRequestIn_b & ~resetReqPrev_q;

  always_comb begin
    resetReqPrev_d = resetRequestIn_b;
    resetInd_d = resetRequestIn_b ? 1'b0 : cpb_pkg::RESET_INDICATOR_ON;
    // Strap taken every reset cycle so the last level before release wins
    // A high pin selects coprocessor mode, so a tied reset indicator forces it
    strap_d = resetRequestIn_b ? strap_q : testBusyIn;
    coproc_d = resetRelease ? strap_q : coprocMode_q;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetReqPrev_q <= 1'b0;
      resetIndicatorOut_q <= 1'b1;
      strap_q <= 1'b0;
      coprocMode_q <= 1'b0;
    end else begin
      resetReqPrev_q <= resetReqPrev_d;
      resetIndicatorOut_q <= resetInd_d;
      strap_q <= strap_d;
      coprocMode_q <= coproc_d;
    end
  end

  // ----------------------------------------------------------------
  // Wait stall and coprocessor busy
  // ----------------------------------------------------------------
  logic stall_d;
  logic busy_d;

  always_comb begin
    stall_d = waitStall_q;
    if (!resetRequestIn_b || coprocMode_q) begin
      stall_d = 1'b0;
    end else if (waitStall_q && !testBusyIn) begin
      stall_d = 1'b0;
    end else if (waitReq && testBusyIn) begin
      stall_d = 1'b1;
    end
    busy_d = coprocMode_q & testBusyIn & resetRequestIn_b;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitStall_q <= 1'b0;
      coprocBusy_q <= 1'b0;
    end else begin
      waitStall_q <= stall_d;
      coprocBusy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Non-maskable interrupt
  // ----------------------------------------------------------------
  logic nmiPrev_q;
  logic nmiPrev_d;
  logic nmiPend_d;
  logic [7:0] nmiType_d;

  always_comb begin
    nmiPrev_d = nmiIn;
    nmiPend_d = nmiPending_q;
    if (!resetRequestIn_b) begin
      nmiPend_d = 1'b0;
    end else if (nmiIn && !nmiPrev_q) begin
      nmiPend_d = 1'b1;
    end else if (nmiAck) begin
      nmiPend_d = 1'b0;
    end
    nmiType_d = cpb_pkg::NMI_TYPE;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmiPrev_q <= 1'b0;
      nmiPending_q <= 1'b0;
      nmiType_q <= 8'h00;
    end else begin
      nmiPrev_q <= nmiPrev_d;
      nmiPending_q <= nmiPend_d;
      nmiType_q <= nmiType_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus and power sequencer
  // ----------------------------------------------------------------
  cpb_pkg::cpb_state_t state_q;
  cpb_pkg::cpb_state_t state_d;
  cpb_pkg::cpb_bus_req_t cyc_q;
  cpb_pkg::cpb_bus_req_t cyc_d;
  cpb_pkg::cpb_bus_pins_t pins_d;
  logic [1:0] dataCnt_q;
  logic [1:0] dataCnt_d;
  logic ack_d;
  logic holdAck_d;
  logic pdown_d;
  logic wakeOut_d;
  logic wakeOe_d;
  logic [15:0] rdata_d;

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    pins_d = busPins_q;
    dataCnt_d = dataCnt_q;
    ack_d = 1'b0;
    rdata_d = busRdata_q;
    holdAck_d = 1'b0;
    pdown_d = 1'b0;
    wakeOut_d = 1'b0;
    wakeOe_d = 1'b0;
    unique case (state_q)
      cpb_pkg::stReset: begin
        if (resetRequestIn_b) begin
          state_d = cpb_pkg::stAlign;
        end
      end
      cpb_pkg::stAlign: begin
        // First fetch waits for the divider to restart in step
        if (clkInFall) begin
          cyc_d = '0;
          cyc_d.valid = 1'b1;
          cyc_d.addr = cpb_pkg::RESET_VECTOR;
          state_d = cpb_pkg::stAddr;
        end
      end
      cpb_pkg::stIdle: begin
        if (holdReq) begin
          state_d = cpb_pkg::stHold;
        end else if (powerDownReq) begin
          state_d = cpb_pkg::stPdown;
        end else if (busReq.valid) begin
          cyc_d = busReq;
          state_d = cpb_pkg::stAddr;
        end
      end
      cpb_pkg::stAddr: begin
        pins_d.adOut = cyc_q.addr[15:0];
        pins_d.adOe = 16'hFFFF;
        pins_d.upperOut = cyc_q.addr[19:16];
        pins_d.upperOe = 1'b1;
        dataCnt_d = 2'h0;
        state_d = cpb_pkg::stData;
      end
      cpb_pkg::stData: begin
        pins_d.upperOut = {cyc_q.dmaOrRefresh, cpb_pkg::UPPER_DATA_ZERO};
        pins_d.adOut = cyc_q.wdata;
        pins_d.adOe = cyc_q.write ? 16'hFFFF : 16'h0000;
        if (narrowBus) begin
          pins_d.adOut[15:8] = cyc_q.addr[15:8];
          pins_d.adOe[15:8] = 8'hFF;
        end
        dataCnt_d = dataCnt_q + 2'h1;
        if (dataCnt_q == cpb_pkg::DATA_CYCLES - 2'h1) begin
          ack_d = 1'b1;
          rdata_d = narrowBus ? {8'h00, muxedAddrDataIn[7:0]} : muxedAddrDataIn;
          pins_d.adOe = 16'h0000;
          state_d = cpb_pkg::stIdle;
        end
      end
      cpb_pkg::stHold: begin
        holdAck_d = 1'b1;
        pins_d.adOe = 16'h0000;
        pins_d.upperOe = 1'b0;
        if (!holdReq) begin
          holdAck_d = 1'b0;
          state_d = cpb_pkg::stIdle;
        end
      end
      cpb_pkg::stPdown: begin
        // Bus pins are left untouched so they keep their levels
        pdown_d = 1'b1;
        wakeOut_d = 1'b1;
        wakeOe_d = 1'b1;
        if (wakeReq) begin
          state_d = cpb_pkg::stWakeDrive;
        end
      end
      cpb_pkg::stWakeDrive: begin
        // Discharge the timing capacitor before letting it charge
        pdown_d = 1'b1;
        wakeOe_d = 1'b1;
        state_d = cpb_pkg::stWakeWait;
      end
      cpb_pkg::stWakeWait: begin
        pdown_d = 1'b1;
        if (powerdownWakeDelayIn) begin
          pdown_d = 1'b0;
          state_d = cpb_pkg::stIdle;
        end
      end
      default: begin
        state_d = cpb_pkg::stReset;
      end
    endcase
    if (!resetRequestIn_b) begin
      state_d = cpb_pkg::stReset;
      pins_d = '0;
      ack_d = 1'b0;
      holdAck_d = 1'b0;
      pdown_d = 1'b0;
      wakeOe_d = 1'b0;
      wakeOut_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= cpb_pkg::stReset;
      cyc_q <= '0;
      busPins_q <= '0;
      dataCnt_q <= 2'h0;
      busAck_q <= 1'b0;
      busRdata_q <= 16'h0000;
      holdAck_q <= 1'b0;
      powerDown_q <= 1'b0;
      powerdownWakeDelayOut_q <= 1'b0;
      powerdownWakeDelayOe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      busPins_q <= pins_d;
      dataCnt_q <= dataCnt_d;
      busAck_q <= ack_d;
      busRdata_q <= rdata_d;
      holdAck_q <= holdAck_d;
      powerDown_q <= pdown_d;
      powerdownWakeDelayOut_q <= wakeOut_d;
      powerdownWakeDelayOe_q <= wakeOe_d;
    end
  end

endmodule
`default_nettype wire

// ==== cpb_pins_chk.sv ====
`default_nettype none
module cpb_pins_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Clock and reset pins
  input wire logic doubleRateClockIn,
  input wire logic halfRateTimingOut_q,
  input wire logic resetRequestIn_b,
  input wire logic resetIndicatorOut_q,
  // Side pins
  input wire logic nmiIn,
  input wire logic nmiPending_q,
  input wire logic [7:0] nmiType_q,
  input wire logic powerDown_q,
  input wire logic holdAck_q,
  // Bus
  input wire logic narrowBus,
  input wire cpb_pkg::cpb_bus_req_t busReq,
  input wire logic busAck_q,
  input wire cpb_pkg::cpb_bus_pins_t busPins_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic [4:0] inHist_q;
  cpb_pkg::cpb_bus_req_t reqLast_q;
  // Input clock history leaves room for the pin synchroniser delay
  always_ff @(posedge core_clk) begin
    inHist_q <= {inHist_q[3:0], doubleRateClockIn};
    reqLast_q <= busReq;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_half_rate;
    $changed(halfRateTimingOut_q) && resetRequestIn_b && !$past(resetIndicatorOut_q)
      |-> |(inHist_q[4:1] & ~inHist_q[3:0]);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate step without fall");
  property p_reset_pins;
    !resetRequestIn_b |=> resetIndicatorOut_q && busPins_q.adOe == 16'h0 && !busPins_q.upperOe;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin state");
  property p_vector;
    $rose(resetRequestIn_b) |-> ##[1:20] busPins_q.upperOe && busPins_q.upperOut == 4'hF
      && busPins_q.adOut == 16'hFFF0;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector fetch");
  property p_addr_phase;
    busAck_q && reqLast_q.valid |-> $past(busPins_q.upperOut, 2) == reqLast_q.addr[19:16]
      && $past(busPins_q.adOut, 2) == reqLast_q.addr[15:0];
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase");
  property p_data_upper;
    busAck_q && reqLast_q.valid |-> $past(busPins_q.upperOut, 1) == {reqLast_q.dmaOrRefresh, 3'h0}
      && $past(busPins_q.upperOe, 1);
  endproperty
  a_data_upper: assert property (p_data_upper) else $error("data phase upper");
  property p_write_data;
    busAck_q && reqLast_q.valid && reqLast_q.write && !narrowBus
      |-> $past(busPins_q.adOe, 1) == 16'hFFFF && $past(busPins_q.adOut, 1) == reqLast_q.wdata;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data phase");
  property p_narrow;
    busAck_q && reqLast_q.valid && narrowBus
      |-> $past(busPins_q.adOut[15:8], 1) == reqLast_q.addr[15:8];
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow high address");
  property p_nmi;
    $rose(nmiIn) && resetRequestIn_b |-> ##[1:3] nmiPending_q && nmiType_q == 8'h02;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not latched");
  property p_hold_float;
    holdAck_q |-> busPins_q.adOe == 16'h0 && !busPins_q.upperOe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("bus driven in hold");
  property p_pdown_keep;
    powerDown_q && $past(powerDown_q) |-> $stable(busPins_q);
  endproperty
  a_pdown_keep: assert property (p_pdown_keep) else $error("pins moved in power-down");
endmodule
bind cpb_pins cpb_pins_chk u_chk (.core_clk, .rst_b, .doubleRateClockIn, .halfRateTimingOut_q,
  .resetRequestIn_b, .resetIndicatorOut_q, .nmiIn, .nmiPending_q, .nmiType_q, .powerDown_q,
  .holdAck_q, .narrowBus, .busReq, .busAck_q, .busPins_q);
`default_nettype wire

// ==== cpb_mem_model.sv ====
`default_nettype none
module cpb_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus pins
  input wire cpb_pkg::cpb_bus_pins_t busPins_q,
  output logic [15:0] muxedAddrDataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr_q;
  logic [15:0] last_q = 16'hA5A5;
  logic wasAddr_q = 1'b0;
  // External latch catches the first cycle of an address drive
  always_ff @(posedge core_clk) begin
    wasAddr_q <= busPins_q.adOe == 16'hFFFF;
    if (busPins_q.adOe == 16'hFFFF && !wasAddr_q) addr_q <= busPins_q.adOut;
    last_q <= muxedAddrDataIn;
  end
  // A released bus wanders so a stale value is never mistaken for data
  always_comb begin
    if (busPins_q.upperOe && busPins_q.adOe[7:0] == 8'h0) muxedAddrDataIn = addr_q ^ 16'h5A3C;
    else muxedAddrDataIn = ~last_q;
  end
endmodule
`default_nettype wire

// ==== cpb_pins_test.sv ====
`default_nettype none
module cpb_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, doubleRateClockIn, emuMode, resetRequestIn_b, tieTest, testDrv, nmiIn;
  logic nmiAck, powerDownReq, wakeReq, capHigh, holdReq, narrowBus, waitReq, pdOut, pdOe;
  logic halfRate, crystalOe, resetInd, coprocMode, nmiPending, powerDown, holdAck, busAck;
  logic crystalOut, waitStall, coprocBusy;
  logic [7:0] nmiType;
  logic [15:0] busRdata, muxIn;
  cpb_pkg::cpb_bus_req_t busReq;
  cpb_pkg::cpb_bus_pins_t busPins;
  int errCount, checkCount;
  wire logic testBusyIn = tieTest ? resetInd : testDrv;
  wire logic wakePin = pdOe ? pdOut : capHigh;
  cpb_pins DUT (.core_clk, .rst_b, .doubleRateClockIn, .halfRateTimingOut_q(halfRate),
    .crystalDriveOut_q(crystalOut), .crystalDriveOe_q(crystalOe), .onCircuitEmulationMode(emuMode),
    .resetRequestIn_b, .resetIndicatorOut_q(resetInd), .testBusyIn, .waitReq,
    .waitStall_q(waitStall), .coprocMode_q(coprocMode), .coprocBusy_q(coprocBusy), .nmiIn, .nmiAck,
    .nmiPending_q(nmiPending), .nmiType_q(nmiType), .powerDownReq, .wakeReq,
    .powerdownWakeDelayIn(wakePin), .powerdownWakeDelayOut_q(pdOut),
    .powerdownWakeDelayOe_q(pdOe), .powerDown_q(powerDown), .holdReq, .holdAck_q(holdAck),
    .narrowBus, .busReq, .busAck_q(busAck), .busRdata_q(busRdata),
    .muxedAddrDataIn(muxIn), .busPins_q(busPins));
  cpb_mem_model u_mem (.core_clk, .busPins_q(busPins), .muxedAddrDataIn(muxIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    doubleRateClockIn = 1'b0;
    #6;
    forever #40 doubleRateClockIn = ~doubleRateClockIn;
  end
  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endSim();
    if (errCount == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic expire(input logic ok);
    if (!ok) begin
      errCount++;
      endSim();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tReset(input logic tie);
    int i;
    tieTest = tie;
    testDrv = 1'b0;
    resetRequestIn_b = 1'b0;
    step(6);
    chk(20'(resetInd), 20'h1, "resetInd");
    chk(20'(busPins.adOe), 20'h0, "resetAdOe");
    resetRequestIn_b = 1'b1;
    for (i = 0; i < 40 && busAck !== 1'b1; i++) step(1);
    expire(busAck === 1'b1);
    tieTest = 1'b0;
    testDrv = 1'b1;
    chk(20'(coprocMode), 20'(tie), "coprocMode");
    step(2);
    chk(20'(coprocBusy), 20'(tie), "coprocBusy");
    testDrv = 1'b0;
    step(2);
    chk(20'(coprocBusy), 20'h0, "coprocIdle");
    testDrv = 1'b1;
    step(1);
  endtask
  task automatic tWait();
    waitReq = 1'b1;
    step(1);
    waitReq = 1'b0;
    step(3);
    chk(20'(waitStall), 20'h1, "waitStall");
    testDrv = 1'b0;
    step(1);
    chk(20'(waitStall), 20'h0, "waitRelease");
    testDrv = 1'b1;
    step(1);
  endtask
  task automatic tClock();
    int n;
    int m;
    logic last;
    logic lastX;
    n = 0;
    m = 0;
    emuMode = 1'b1;
    last = halfRate;
    lastX = crystalOut;
    repeat (64) begin
      step(1);
      if (halfRate !== last) n++;
      if (crystalOut !== lastX) m++;
      last = halfRate;
      lastX = crystalOut;
    end
    chk(20'(n >= 7 && n <= 9), 20'h1, "halfRateSteps");
    chk(20'(m), 20'h10, "crystalSteps");
    chk(20'(crystalOe), 20'h1, "crystalOe");
    emuMode = 1'b0;
  endtask
  task automatic tBus(input logic wr, input logic dma, input logic [19:0] a, input logic [15:0] wd);
    int i;
    busReq = '{1'b1, wr, dma, a, wd};
    for (i = 0; i < 20 && busAck !== 1'b1; i++) step(1);
    expire(busAck === 1'b1);
    busReq.valid = 1'b0;
    if (!wr) chk(20'(busRdata), narrowBus ? 20'(a[7:0] ^ 8'h3C) : 20'(a[15:0] ^ 16'h5A3C), "rdata");
    if (wr) chk(20'(busPins.adOut), 20'(wd), "wdata");
    step(1);
  endtask
  task automatic tNmi();
    nmiIn = 1'b1;
    step(3);
    chk(20'(nmiPending), 20'h1, "nmiPending");
    chk(20'(nmiType), 20'h2, "nmiType");
    nmiAck = 1'b1;
    step(1);
    chk(20'(nmiPending), 20'h0, "nmiCleared");
    nmiAck = 1'b0;
    nmiIn = 1'b0;
  endtask
  task automatic tHold();
    int i;
    holdReq = 1'b1;
    for (i = 0; i < 10 && holdAck !== 1'b1; i++) step(1);
    expire(holdAck === 1'b1);
    chk(20'({busPins.adOe, busPins.upperOe}), 20'h0, "holdOe");
    holdReq = 1'b0;
    step(2);
  endtask
  task automatic tPdown();
    int i;
    cpb_pkg::cpb_bus_pins_t held;
    capHigh = 1'b0;
    powerDownReq = 1'b1;
    for (i = 0; i < 10 && powerDown !== 1'b1; i++) step(1);
    expire(powerDown === 1'b1);
    held = busPins;
    powerDownReq = 1'b0;
    wakeReq = 1'b1;
    step(1);
    wakeReq = 1'b0;
    step(8);
    chk(20'(powerDown), 20'h1, "wakeDelay");
    chk(20'(busPins === held), 20'h1, "pdPins");
    capHigh = 1'b1;
    for (i = 0; i < 10 && powerDown !== 1'b0; i++) step(1);
    expire(powerDown === 1'b0);
  endtask
  task automatic tAbort();
    busReq = '{1'b1, 1'b0, 1'b0, 20'h54321, 16'h0};
    step(2);
    resetRequestIn_b = 1'b0;
    busReq.valid = 1'b0;
    step(2);
    chk(20'({busPins.upperOe, busAck}), 20'h0, "abort");
  endtask
  initial begin
    rst_b = 1'b0;
    {emuMode, resetRequestIn_b, tieTest, nmiIn, nmiAck, powerDownReq} = 6'h0;
    {wakeReq, capHigh, holdReq, narrowBus, waitReq} = 5'h0;
    testDrv = 1'b1;
    busReq = '0;
    step(4);
    rst_b = 1'b1;
    tReset(1'b1);
    tClock();
    tBus(1'b0, 1'b0, 20'h12345, 16'h0);
    tBus(1'b1, 1'b1, 20'hABCDE, 16'hC0DE);
    narrowBus = 1'b1;
    tBus(1'b0, 1'b0, 20'h0FF81, 16'h0);
    narrowBus = 1'b0;
    tNmi();
    tHold();
    tPdown();
    tAbort();
    tReset(1'b0);
    tWait();
    tBus(1'b0, 1'b1, 20'hFFFFF, 16'h0);
    endSim();
  end
endmodule
`default_nettype wire
